/* verilog/eps_consts.svh */
// Purpose: Offsets, field positions, reset values and constants of the position scaling block
// Assumes: 8-bit register addresses, 32-bit register data
// Notes:   Named numbers of the design live here; unit codes and zero literals stay in the code
`ifndef EPS_CONSTS_SVH
`define EPS_CONSTS_SVH

// Register offsets
`define EPS_A_CTRL    8'h00
`define EPS_A_CPT     8'h04
`define EPS_A_ROLL    8'h08
`define EPS_A_PRESET  8'h0c
`define EPS_A_CMD     8'h10
`define EPS_A_STATUS  8'h14
`define EPS_A_POS     8'h18
`define EPS_A_VEL     8'h1c
`define EPS_A_OFFSET  8'h20
`define EPS_A_IP      8'h24
`define EPS_A_MASK    8'h28
`define EPS_A_GW      8'h2c

// Control fields
`define EPS_CTRL_SCALE 0
`define EPS_CTRL_PROT  1
`define EPS_CTRL_VLO   2
`define EPS_CTRL_VHI   3
`define EPS_CTRL_DIR   4

// Command fields
`define EPS_CMD_SAVE_OFF 0
`define EPS_CMD_SAVE_PAR 1
`define EPS_CMD_RESTORE  2

// Factory values
`define EPS_CTRL_DEF   5'h01
`define EPS_CPT_DEF    17'h10000
`define EPS_ROLL_DEF   31'h00000000
`define EPS_OFF_DEF    31'h00000000
`define EPS_IP_DEF     32'hc0a80032
`define EPS_MASK_DEF   32'hffffff00
`define EPS_GW_DEF     32'hc0a80001
`define EPS_SW_DEFNET  12'h999

// Counts and turns per variant
`define EPS_FULL_16    31'h00010000
`define EPS_FULL_28    31'h10000000
`define EPS_FULL_30    31'h40000000
`define EPS_TURNS_16   15'h0001
`define EPS_TURNS_28   15'h1000
`define EPS_TURNS_30   15'h4000

// Velocity scaling: raw velocity is in counts per second at 65536 counts per turn
`define EPS_VMUL_60    23'h00003c
`define EPS_VMUL_C60   7'h3c
`define EPS_VDEN_1     56'h00000000010000
`define EPS_VDEN_1000  56'h00000003e80000
`define EPS_VDEN_10    56'h000000000a0000
`define EPS_VDEN_100   56'h00000000640000

// Divider
`define EPS_DW         56
`define EPS_DCNT_LAST  6'h37

`endif

/* verilog/eps_pkg.sv */
// Purpose: Types shared by the position scaling block
// Assumes: Constants come from eps_consts.svh
// Notes:   Types only
package eps_pkg;
  typedef enum logic [1:0] {EPS_V16 = 2'h0, EPS_V28 = 2'h1, EPS_V30 = 2'h2} eps_variant_t;
  typedef enum logic [1:0] {EPS_IDLE = 2'h0, EPS_RUN = 2'h1, EPS_DONE = 2'h3} eps_div_state_t;
  typedef logic [55:0] eps_word_t;
endpackage

/* verilog/eps_div_if.sv */
// Purpose: Request and answer bundle between core and divider
// Assumes: Same clock on both sides
// Notes:   start is honoured only while the unit is idle
`timescale 1ns/100ps
interface eps_div_if;
  import eps_pkg::*;
  logic      start;
  logic      busy;
  logic      done;
  eps_word_t dividend;
  eps_word_t divisor;
  eps_word_t quotient;
  eps_word_t remainder;
  modport req  (output start, dividend, divisor, input busy, done, quotient, remainder);
  modport unit (input start, dividend, divisor, output busy, done, quotient, remainder);
endinterface

/* verilog/eps_div.sv */
// Purpose: Restoring divider, one quotient bit per cycle
// Assumes: Divisor never zero
// Notes:   56 cycles of work, done stands one cycle
`timescale 1ns/100ps
`include "eps_consts.svh"
module eps_div
  import eps_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // Divider bundle
  eps_div_if.unit   div_if
);
  eps_div_state_t state_r;
  eps_word_t      num_r;
  eps_word_t      den_r;
  eps_word_t      rem_r;
  logic [5:0]     cnt_r;
  logic [56:0]    trial_w;
  logic           fits_w;

  //////////////////////////////////////////////////////////////////////////////
  // Trial subtraction: one extra bit since the shifted remainder may exceed the word
  assign trial_w = {rem_r, num_r[55]};
  assign fits_w  = trial_w >= {1'b0, den_r};

  assign div_if.busy      = state_r != EPS_IDLE;
  assign div_if.done      = state_r == EPS_DONE;
  assign div_if.quotient  = num_r;
  assign div_if.remainder = rem_r;

  // Sequencer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_r <= EPS_IDLE;
      cnt_r   <= 6'h00;
    end else begin
      unique case (state_r)
        EPS_IDLE: if (div_if.start) begin
          state_r <= EPS_RUN;
          cnt_r   <= `EPS_DCNT_LAST;
        end
        EPS_RUN: begin
          cnt_r <= cnt_r - 6'h01;
          if (cnt_r == 6'h00) state_r <= EPS_DONE;
        end
        EPS_DONE: state_r <= EPS_IDLE;
        default:  state_r <= EPS_IDLE;
      endcase
    end
  end

  // Datapath; quotient bits shift in behind the dividend
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      num_r <= 56'h0;
      den_r <= 56'h0;
      rem_r <= 56'h0;
    end else if (state_r == EPS_IDLE && div_if.start) begin
      num_r <= div_if.dividend;
      den_r <= div_if.divisor;
      rem_r <= 56'h0;
    end else if (state_r == EPS_RUN) begin
      num_r <= {num_r[54:0], fits_w};
      rem_r <= fits_w ? trial_w[55:0] - den_r : trial_w[55:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wrapped value always below the modulus
  rem_range_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    div_if.done |-> rem_r < den_r) else $error("remainder not below divisor");
endmodule

/* verilog/eps_core.sv */
// Purpose: Position scaling, roll-over, preset and offset storage for a resolver encoder
// Assumes: Raw position and velocity arrive on ref_clk_in; switches are asynchronous pins
// Notes:   Register port answers a read one cycle later; NVM writes are one-cycle pulses
`timescale 1ns/100ps
`include "eps_consts.svh"
module eps_core
  import eps_pkg::*;
#(
  parameter eps_variant_t VARIANT = EPS_V30
)(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Sensor data
  input  wire logic [29:0] raw_pos_in,
  input  wire logic [31:0] raw_vel_in,
  // Pins
  input  wire logic        reset_switch_in,
  input  wire logic [11:0] addr_switch_in,
  // Results
  output logic      [30:0] position_out,
  output logic      [31:0] velocity_out,
  // Non-volatile store
  output logic             nvm_offset_wr_out,
  output logic      [30:0] nvm_offset_data_out,
  output logic             nvm_param_save_out,
  // Network addressing
  output logic      [31:0] ip_addr_out,
  output logic      [31:0] subnet_out,
  output logic      [31:0] gateway_out
);
  eps_div_if pos_if ();
  eps_div_if vel_if ();

  logic [4:0]  ctrl_r;
  logic [16:0] cpt_r;
  logic [30:0] roll_r;
  logic [30:0] off_r;
  logic [30:0] r_r;
  logic        rej_r;
  logic        vel_neg_r;
  logic [31:0] ip_r;
  logic [31:0] mask_r;
  logic [31:0] gw_r;
  logic [2:0]  rsw_r;
  logic        rsw_lvl_r;
  logic [11:0] asw1_r;
  logic [11:0] asw2_r;
  logic [11:0] asw3_r;
  logic        sw_cap_r;
  logic        sw999_r;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic wr_ctrl_w, wr_cpt_w, wr_roll_w, wr_preset_w, wr_cmd_w, wr_stat_w;
  logic save_off_w, save_par_w, restore_w, cfg_clr_w;
  assign wr_ctrl_w   = reg_wr_in && reg_addr_in == `EPS_A_CTRL;
  assign wr_cpt_w    = reg_wr_in && reg_addr_in == `EPS_A_CPT;
  assign wr_roll_w   = reg_wr_in && reg_addr_in == `EPS_A_ROLL;
  assign wr_preset_w = reg_wr_in && reg_addr_in == `EPS_A_PRESET;
  assign wr_cmd_w    = reg_wr_in && reg_addr_in == `EPS_A_CMD;
  assign wr_stat_w   = reg_wr_in && reg_addr_in == `EPS_A_STATUS;
  assign save_off_w  = wr_cmd_w && reg_wdata_in[`EPS_CMD_SAVE_OFF];
  assign save_par_w  = wr_cmd_w && reg_wdata_in[`EPS_CMD_SAVE_PAR];
  assign restore_w   = wr_cmd_w && reg_wdata_in[`EPS_CMD_RESTORE];
  // A new counts-per-turn or roll-over value, or a restore, invalidates the old reference, so the offset is cleared
  assign cfg_clr_w   = restore_w || wr_cpt_w || wr_roll_w;

  //////////////////////////////////////////////////////////////////////////////
  // Variant figures and modulus
  logic        scale_w;
  logic [29:0] raw_m_w;
  logic [30:0] full_raw_w;
  logic [14:0] turns_w;
  logic [31:0] cpt_turns_w;
  logic [46:0] scaled_w;
  logic [30:0] term_w;
  logic [30:0] mod_w;
  assign scale_w     = ctrl_r[`EPS_CTRL_SCALE];
  assign raw_m_w     = VARIANT == EPS_V16 ? {14'h0, raw_pos_in[15:0]} :
                       VARIANT == EPS_V28 ? {2'h0, raw_pos_in[27:0]} : raw_pos_in;
  assign full_raw_w  = VARIANT == EPS_V16 ? `EPS_FULL_16 : VARIANT == EPS_V28 ? `EPS_FULL_28 : `EPS_FULL_30;
  assign turns_w     = VARIANT == EPS_V16 ? `EPS_TURNS_16 : VARIANT == EPS_V28 ? `EPS_TURNS_28 : `EPS_TURNS_30;
  assign cpt_turns_w = cpt_r * turns_w;
  assign scaled_w    = raw_m_w * cpt_r;
  assign term_w      = scale_w ? scaled_w[46:16] : {1'b0, raw_m_w};
  // Roll-over wins when set; a full-count value therefore leaves the position as is
  assign mod_w       = roll_r != 31'h0 ? roll_r :
                       scale_w ? cpt_turns_w[30:0] : full_raw_w;

  // Position path: scaled counts reduced by the modulus in the divider
  assign pos_if.start    = !pos_if.busy;
  assign pos_if.dividend = {25'h0, term_w};
  assign pos_if.divisor  = {25'h0, mod_w};

  logic [31:0] sum_w;
  logic [30:0] pos_nxt;
  assign sum_w   = {1'b0, r_r} + {1'b0, off_r};
  assign pos_nxt = sum_w >= {1'b0, mod_w} ? 31'(sum_w - {1'b0, mod_w}) : sum_w[30:0];

  //////////////////////////////////////////////////////////////////////////////
  // Preset and switch offsets; limit is modulus minus one in every mode
  logic        preset_ok_w;
  logic [30:0] pval_w;
  logic [30:0] off_preset_w;
  logic [30:0] off_zero_w;
  logic        sw_evt_w;
  logic [30:0] off_nxt_w;
  logic        off_chg_w;
  assign pval_w       = reg_wdata_in[30:0];
  assign preset_ok_w  = reg_wdata_in < {1'b0, mod_w};
  assign off_preset_w = pval_w >= r_r ? pval_w - r_r : pval_w + mod_w - r_r;
  assign off_zero_w   = r_r == 31'h0 ? 31'h0 : mod_w - r_r;
  assign sw_evt_w     = rsw_r[1] && rsw_r[2] && !rsw_lvl_r;
  assign off_nxt_w    = cfg_clr_w ? `EPS_OFF_DEF :
                        sw_evt_w ? off_zero_w :
                        (wr_preset_w && preset_ok_w) ? off_preset_w : off_r;
  assign off_chg_w    = off_nxt_w != off_r;

  //////////////////////////////////////////////////////////////////////////////
  // Velocity path: numerator and denominator per protocol and unit
  logic [1:0]  vunit_w;
  logic        prot_w;
  logic [31:0] mag_w;
  logic [22:0] mult_w;
  logic [54:0] num_w;
  eps_word_t   den_w;
  assign vunit_w = ctrl_r[`EPS_CTRL_VHI:`EPS_CTRL_VLO];
  assign prot_w  = ctrl_r[`EPS_CTRL_PROT];
  assign mag_w   = raw_vel_in[31] ? -raw_vel_in : raw_vel_in;
  // Only rpm ignores counts-per-turn, even with position scaling off
  assign mult_w  = vunit_w == 2'h3 ? `EPS_VMUL_60 :
                   (vunit_w == 2'h2 && !prot_w) ? 23'(cpt_r * `EPS_VMUL_C60) : {6'h0, cpt_r};
  assign num_w   = mag_w * mult_w;
  assign den_w   = !prot_w ? (vunit_w == 2'h1 ? `EPS_VDEN_1000 : `EPS_VDEN_1) :
                   vunit_w == 2'h1 ? `EPS_VDEN_10 :
                   vunit_w == 2'h2 ? `EPS_VDEN_100 : `EPS_VDEN_1;
  assign vel_if.start    = !vel_if.busy;
  assign vel_if.dividend = {1'b0, num_w};
  assign vel_if.divisor  = den_w;

  eps_div u_pos_div (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .div_if     (pos_if)
  );

  eps_div u_vel_div (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .div_if     (vel_if)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; second and third stage must agree before a change counts
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsw_r  <= 3'h0;
      asw1_r <= 12'h000;
      asw2_r <= 12'hfff; // Differs from stage 3 so reset values never pass as a reading
      asw3_r <= 12'h000;
    end else begin
      rsw_r  <= {rsw_r[1:0], reset_switch_in};
      asw1_r <= addr_switch_in;
      asw2_r <= asw1_r;
      asw3_r <= asw2_r;
    end
  end

  // Switch level and power-up capture of the address switches
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsw_lvl_r <= 1'b0;
      sw_cap_r  <= 1'b0;
      sw999_r   <= 1'b0;
    end else begin
      if (rsw_r[1] == rsw_r[2]) rsw_lvl_r <= rsw_r[2];
      if (!sw_cap_r && asw2_r == asw3_r) begin
        sw_cap_r <= 1'b1;
        sw999_r  <= asw3_r == `EPS_SW_DEFNET;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers; restore leaves addressing alone
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || restore_w) begin
      ctrl_r <= `EPS_CTRL_DEF;
      cpt_r  <= `EPS_CPT_DEF;
      roll_r <= `EPS_ROLL_DEF;
    end else begin
      if (wr_ctrl_w) ctrl_r <= reg_wdata_in[4:0];
      if (wr_cpt_w)  cpt_r  <= reg_wdata_in[16:0];
      if (wr_roll_w) roll_r <= reg_wdata_in[30:0];
    end
  end

  // Addressing registers, touched only by their own writes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ip_r   <= `EPS_IP_DEF;
      mask_r <= `EPS_MASK_DEF;
      gw_r   <= `EPS_GW_DEF;
    end else begin
      if (reg_wr_in && reg_addr_in == `EPS_A_IP)   ip_r   <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `EPS_A_MASK) mask_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `EPS_A_GW)   gw_r   <= reg_wdata_in;
    end
  end

  // Offset and reject flag; the preset value itself is never stored
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      off_r <= `EPS_OFF_DEF;
      rej_r <= 1'b0;
    end else begin
      off_r <= off_nxt_w;
      // Set wins over a clear in the same cycle
      rej_r <= (wr_preset_w && !preset_ok_w) || (rej_r && !(wr_stat_w && reg_wdata_in[0]));
    end
  end

  // Non-volatile requests; offset storage carries no parameter save
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      nvm_offset_wr_out   <= 1'b0;
      nvm_offset_data_out <= 31'h0;
      nvm_param_save_out  <= 1'b0;
    end else begin
      nvm_offset_wr_out   <= sw_evt_w || save_off_w ||
                             (off_chg_w && roll_r != 31'h0);
      nvm_offset_data_out <= off_nxt_w;
      nvm_param_save_out  <= save_par_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Results
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      r_r          <= 31'h0;
      vel_neg_r    <= 1'b0;
      position_out <= 31'h0;
      velocity_out <= 32'h0;
    end else begin
      if (pos_if.done) r_r <= pos_if.remainder[30:0];
      if (vel_if.start) vel_neg_r <= raw_vel_in[31];
      if (vel_if.done) velocity_out <= vel_neg_r ? -vel_if.quotient[31:0] : vel_if.quotient[31:0];
      position_out <= pos_nxt;
    end
  end

  // Addressing outputs; a 999 switch setting overrides the stored values
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ip_addr_out <= `EPS_IP_DEF;
      subnet_out  <= `EPS_MASK_DEF;
      gateway_out <= `EPS_GW_DEF;
    end else begin
      ip_addr_out <= sw999_r ? `EPS_IP_DEF : ip_r;
      subnet_out  <= sw999_r ? `EPS_MASK_DEF : mask_r;
      gateway_out <= sw999_r ? `EPS_GW_DEF : gw_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses and the preset register read zero
  logic [31:0] rd_w;
  assign rd_w = reg_addr_in == `EPS_A_CTRL   ? {27'h0, ctrl_r} :
                reg_addr_in == `EPS_A_CPT    ? {15'h0, cpt_r} :
                reg_addr_in == `EPS_A_ROLL   ? {1'b0, roll_r} :
                reg_addr_in == `EPS_A_STATUS ? {30'h0, sw999_r, rej_r} :
                reg_addr_in == `EPS_A_POS    ? {1'b0, position_out} :
                reg_addr_in == `EPS_A_VEL    ? velocity_out :
                reg_addr_in == `EPS_A_OFFSET ? {1'b0, off_r} :
                reg_addr_in == `EPS_A_IP     ? ip_r :
                reg_addr_in == `EPS_A_MASK   ? mask_r :
                reg_addr_in == `EPS_A_GW     ? gw_r : 32'h0;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) reg_rdata_out <= 32'h0;
    else           reg_rdata_out <= reg_rd_in ? rd_w : 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  preset_reject_a: assert property (
    wr_preset_w && !preset_ok_w |=> $stable(off_r) && rej_r) else $error("rejected preset moved offset");
  preset_apply_a: assert property (
    wr_preset_w && preset_ok_w && !sw_evt_w |=> off_r == $past(off_preset_w)) else $error("preset offset wrong");
  auto_store_a: assert property (
    off_chg_w && roll_r != 31'h0 |=> nvm_offset_wr_out && nvm_offset_data_out == off_r)
    else $error("offset change not stored");
  volatile_off_a: assert property (
    roll_r == 31'h0 && !sw_evt_w && !save_off_w |=> !nvm_offset_wr_out) else $error("unrequested offset store");
  switch_zero_a: assert property (
    sw_evt_w |=> nvm_offset_wr_out && off_r == $past(off_zero_w)) else $error("switch reset not stored");
  param_save_a: assert property (
    !save_par_w |=> !nvm_param_save_out) else $error("parameter save without command");
  restore_keep_a: assert property (
    restore_w |=> $stable(ip_r) && $stable(gw_r) && ctrl_r == `EPS_CTRL_DEF && cpt_r == `EPS_CPT_DEF && off_r == 31'h0)
    else $error("restore defaults wrong");
  default_ip_a: assert property (
    sw999_r |=> ip_addr_out == `EPS_IP_DEF) else $error("default address not used");

  preset_ok_c: cover property (wr_preset_w && preset_ok_w ##1 nvm_offset_wr_out);
  preset_bad_c: cover property (wr_preset_w && !preset_ok_w);
  switch_c:     cover property (sw_evt_w);
  rpm_vel_c:    cover property (vunit_w == 2'h3 && vel_if.done);
endmodule

/* tb/eps_ctl_model.sv */
// Purpose: Network controller model driving the register port of the position block
// Assumes: One clock; strobes last one cycle and change just after rising edges
// Notes:   Write data is inverted on release so stale values never look valid
`timescale 1ns/100ps
`include "eps_consts.svh"
module eps_ctl_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Register port
  output logic      [7:0]  reg_addr_out,
  output logic      [31:0] reg_wdata_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  input  wire logic [31:0] reg_rdata_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 32'h00000000;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out   <= 1'b0;
    #1 d = reg_rdata_in;
  endtask

  // Value travels with every preset command, nothing is kept here
  task automatic preset(input logic [31:0] p);
    wr(`EPS_A_PRESET, p);
  endtask

  // Parameters need their own save command
  task automatic save_params();
    wr(`EPS_A_CMD, 32'h00000002);
  endtask
endmodule

/* tb/tb_encoder_position_scaling_preset.sv */
// Purpose: Self-checking bench for the position scaling block
// Assumes: 30-bit variant, raw position set by the tests, controller model on the register port
// Notes:   Waits of 150 cycles cover the ~58-cycle recompute of position and velocity
`timescale 1ns/100ps
`include "eps_consts.svh"
module tb_encoder_position_scaling_preset;
  import eps_pkg::*;
  logic        ref_clk_in;
  logic        rst_n_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [29:0] raw_pos_in;
  logic [31:0] raw_vel_in;
  logic        reset_switch_in;
  logic [30:0] position_out;
  logic [31:0] velocity_out;
  logic        nvm_offset_wr_out;
  logic        nvm_param_save_out;
  logic [31:0] ip_addr_out;
  logic [31:0] subnet_out;
  logic [31:0] gateway_out;
  logic [30:0] nvm_offset_data_out;
  logic [11:0] addr_sw;
  int          errors;
  int          checked;
  int          n_off;
  int          n_par;
  logic [31:0] vt [8] = '{32'h00010000, 32'h00000041, 32'h003c0000, 32'h0000003c,
                          32'h00010000, 32'h00001999, 32'h0000028f, 32'h0000003c};

  ////////////////////////////////////////////////////////////////////////////
  // Clock and model instances; address switches start away from 999
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  eps_ctl_model ctl (.ref_clk_in(ref_clk_in), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
                     .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata));
  eps_core #(.VARIANT(EPS_V30)) DUT (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .raw_pos_in(raw_pos_in),
    .raw_vel_in(raw_vel_in), .reset_switch_in(reset_switch_in), .addr_switch_in(addr_sw),
    .position_out(position_out), .velocity_out(velocity_out), .nvm_offset_wr_out(nvm_offset_wr_out),
    .nvm_offset_data_out(nvm_offset_data_out), .nvm_param_save_out(nvm_param_save_out),
    .ip_addr_out(ip_addr_out), .subnet_out(subnet_out), .gateway_out(gateway_out));

  // Count store pulses, since they stand only one cycle
  always @(posedge ref_clk_in) begin
    if (nvm_offset_wr_out === 1'b1) n_off <= n_off + 1;
    if (nvm_param_save_out === 1'b1) n_par <= n_par + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    ctl.rd(a, d);
    chk(what, d, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rchk(`EPS_A_CTRL, 32'h00000001, "ctrl");
    rchk(`EPS_A_CPT, 32'h00010000, "cpt");
    rchk(`EPS_A_ROLL, 32'h00000000, "roll");
    rchk(`EPS_A_OFFSET, 32'h00000000, "offset");
    chk("ip", ip_addr_out, 32'hc0a80032);
    chk("mask", subnet_out, 32'hffffff00);
    chk("gw", gateway_out, 32'hc0a80001);
    $display("test defaults done");
  endtask
  // Preset, save and switch while roll-over is zero
  task automatic t_preset_volatile();
    int n0;
    n0 = n_off;
    // The preset uses the last computed count, so let the first one finish
    idle(150);
    ctl.preset(32'd5000);
    idle(150);
    chk("pos", {1'b0, position_out}, 32'd5000);
    chk("no auto store", n_off, n0);
    ctl.wr(`EPS_A_CMD, 32'h00000001);
    idle(3);
    chk("save store", n_off, n0 + 1);
    reset_switch_in <= 1'b1;
    idle(150);
    reset_switch_in <= 1'b0;
    chk("switch pos", {1'b0, position_out}, 32'd0);
    chk("switch store", n_off, n0 + 2);
    $display("test preset volatile done");
  endtask
  // Nonzero roll-over: limit, auto store and wrap
  task automatic t_rollover();
    int n0;
    ctl.wr(`EPS_A_ROLL, 32'd1000);
    idle(3);
    n0 = n_off;
    ctl.preset(32'd1000);
    idle(150);
    rchk(`EPS_A_STATUS, 32'h00000001, "reject");
    chk("reject store", n_off, n0);
    ctl.wr(`EPS_A_STATUS, 32'h00000001);
    ctl.preset(32'd999);
    idle(150);
    chk("pos max", {1'b0, position_out}, 32'd999);
    chk("auto store", n_off, n0 + 1);
    chk("store data", {1'b0, nvm_offset_data_out}, 32'd899);
    raw_pos_in <= 30'd101;
    idle(150);
    chk("wrap", {1'b0, position_out}, 32'd0);
    chk("no param save", n_par, 0);
    ctl.save_params();
    idle(3);
    chk("param save", n_par, 1);
    $display("test rollover done");
  endtask
  // Every unit of both protocol groups, then counts-per-turn scaling
  task automatic t_velocity();
    for (int i = 0; i < 8; i++) begin
      ctl.wr(`EPS_A_CTRL, 32'h00000001 | (32'(i / 4) << 1) | (32'(i % 4) << 2));
      idle(150);
      chk("vel", velocity_out, vt[i]);
    end
    ctl.wr(`EPS_A_CPT, 32'h00008000);
    ctl.wr(`EPS_A_CTRL, 32'h00000000);
    idle(150);
    chk("vel unscaled", velocity_out, 32'h00008000);
    $display("test velocity done");
  endtask
  task automatic t_restore();
    ctl.wr(`EPS_A_IP, 32'h0a000001);
    ctl.wr(`EPS_A_CMD, 32'h00000004);
    idle(3);
    rchk(`EPS_A_IP, 32'h0a000001, "ip kept");
    chk("ip out", ip_addr_out, 32'h0a000001);
    rchk(`EPS_A_CTRL, 32'h00000001, "ctrl");
    rchk(`EPS_A_CPT, 32'h00010000, "cpt");
    rchk(`EPS_A_ROLL, 32'h00000000, "roll");
    $display("test restore done");
  endtask
  // Turns beyond one revolution, full-count roll-over, unscaled range
  task automatic t_turns();
    int n0;
    raw_pos_in <= 30'd200000;
    ctl.wr(`EPS_A_CPT, 32'd360);
    ctl.wr(`EPS_A_ROLL, 32'd64800);
    idle(150);
    chk("turns pos", {1'b0, position_out}, 32'd1098);
    ctl.wr(`EPS_A_ROLL, 32'd5898240);
    idle(150);
    chk("full roll pos", {1'b0, position_out}, 32'd1098);
    n0 = n_off;
    ctl.preset(32'd7);
    idle(3);
    chk("full roll store", n_off, n0 + 1);
    ctl.wr(`EPS_A_CTRL, 32'h00000000);
    ctl.wr(`EPS_A_ROLL, 32'h00000000);
    idle(150);
    ctl.preset(32'h3fffffff);
    idle(150);
    chk("unscaled max", {1'b0, position_out}, 32'h3fffffff);
    $display("test turns done");
  endtask
  // Second reset with the address switches at 999
  task automatic t_default_net();
    addr_sw  <= 12'h999;
    rst_n_in <= 1'b0;
    idle(10);
    rst_n_in <= 1'b1;
    idle(8);
    rchk(`EPS_A_STATUS, 32'h00000002, "switch 999");
    ctl.wr(`EPS_A_IP, 32'h0a000001);
    idle(3);
    chk("ip forced", ip_addr_out, 32'hc0a80032);
    $display("test default net done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well beyond the ~3000 cycles the tests need
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    checked = 0;
    n_off = 0;
    n_par = 0;
    rst_n_in = 1'b0;
    raw_pos_in = 30'd100;
    raw_vel_in = 32'h00010000;
    reset_switch_in = 1'b0;
    addr_sw = 12'h000;
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    idle(4);
    t_defaults();
    t_preset_volatile();
    t_rollover();
    t_velocity();
    t_restore();
    t_turns();
    t_default_net();
    stop_test();
  end
endmodule
